//--- src/misc_sync_pkg.sv
// ---------------------------------------------------------------------------
// misc sync control package
// ---------------------------------------------------------------------------
// holds offsets, field positions, reset values and state codes for the
// miscellaneous and sync control register bank and its serial write port.
// assumes nothing of its surroundings.
package misc_sync_pkg;

  // -------------------------------------------------------------------------
  // serial frame layout
  // -------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 28;
  localparam int FRAME_BITS = ADDR_W + DATA_W;
  localparam int COUNT_W = 6;
  localparam logic [COUNT_W-1:0] FRAME_COUNT = 6'h24;   // 36 bits per frame
  localparam logic [COUNT_W-1:0] OVER_COUNT = 6'h25;    // more bits than a frame

  // -------------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SOFT_RESET_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] OUTPUT_ENABLE_OFS = 8'h11;
  localparam logic [ADDR_W-1:0] TEST_REG_A_OFS = 8'h12;
  localparam logic [ADDR_W-1:0] TEST_REG_B_OFS = 8'h13;
  localparam logic [ADDR_W-1:0] TIMING_CORE_RELEASE_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] CLOCK_INPUT_BIAS_OFS = 8'h15;
  localparam logic [ADDR_W-1:0] TEST_REG_C_OFS = 8'h16;
  localparam logic [ADDR_W-1:0] FRAME_LOAD_CONTROL_OFS = 8'h17;
  localparam logic [ADDR_W-1:0] TEST_REG_D_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] TEST_REG_E_OFS = 8'h19;
  localparam logic [ADDR_W-1:0] TEST_REG_F_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] SYNC_POLARITY_OFS = 8'h21;
  localparam logic [ADDR_W-1:0] TEST_REG_G_OFS = 8'h22;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int SOFT_RESET_BIT = 0;
  localparam int OUTPUT_ENABLE_BIT = 0;
  localparam int CORE_RELEASE_BIT = 0;
  localparam int CLOCK_BIAS_BIT = 0;
  localparam int SYNC_POLARITY_BIT = 0;
  localparam int LINE_W = 13;
  localparam int LOAD_LINE_LSB = 0;
  localparam int LOAD_INHIBIT_BIT = 13;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic SOFT_RESET_RST = 1'b0;
  localparam logic OUTPUT_ENABLE_RST = 1'b0;
  localparam logic CORE_RELEASE_RST = 1'b0;
  localparam logic CLOCK_BIAS_RST = 1'b0;
  localparam logic LOAD_INHIBIT_RST = 1'b0;
  localparam logic SYNC_POLARITY_RST = 1'b0;
  localparam logic [LINE_W-1:0] LOAD_LINE_RST = 13'h0000;

  // -------------------------------------------------------------------------
  // serial port states
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SP_IDLE = 3'b001,
    SP_SHIFT = 3'b010,
    SP_COMMIT = 3'b100
  } serial_state_t;

endpackage

//--- src/serial_write_port.sv
// serial write port of the register bank
// assumes sckSync, sdataSync and loadSync_n are already synchronised to clock
`timescale 1ns/10ps
module serial_write_port
  import misc_sync_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sckSync,
  input wire logic sdataSync,
  input wire logic loadSync_n,
  output logic writeStrobe,
  output logic [ADDR_W-1:0] writeAddr,
  output logic [DATA_W-1:0] writeData
);

  serial_state_t state_reg;
  logic sckPrev_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic [COUNT_W-1:0] count_reg;
  logic sckRise;

  // -------------------------------------------------------------------------
  // edge of shift clock
  // -------------------------------------------------------------------------
  assign sckRise = sckSync & ~sckPrev_reg;

  // previous shift clock level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sckPrev_reg <= 1'b0;
    end else begin
      sckPrev_reg <= sckSync;
    end
  end

  // frame state: load low opens, load high closes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= SP_IDLE;
    end else begin
      case (state_reg)
        SP_IDLE: begin
          if (!loadSync_n) begin
            state_reg <= SP_SHIFT;
          end
        end
        SP_SHIFT: begin
          if (loadSync_n) begin
            state_reg <= SP_COMMIT;
          end
        end
        SP_COMMIT: state_reg <= SP_IDLE;
        default: state_reg <= SP_IDLE;
      endcase
    end
  end

  // shift in lsb first, count saturates past a whole frame
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_reg <= '0;
      count_reg <= '0;
    end else if (state_reg == SP_IDLE) begin
      count_reg <= '0;
    end else if (state_reg == SP_SHIFT && sckRise && !loadSync_n) begin
      shift_reg <= {sdataSync, shift_reg[FRAME_BITS-1:1]};
      if (count_reg != OVER_COUNT) begin
        count_reg <= count_reg + 6'h01;
      end
    end
  end

  // commit only a frame of exactly 36 bits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      writeStrobe <= 1'b0;
      writeAddr <= '0;
      writeData <= '0;
    end else begin
      writeStrobe <= (state_reg == SP_COMMIT) && (count_reg == FRAME_COUNT);
      if (state_reg == SP_COMMIT) begin
        writeAddr <= shift_reg[ADDR_W-1:0];
        writeData <= shift_reg[FRAME_BITS-1:ADDR_W];
      end
    end
  end

endmodule

//--- src/misc_sync_control_regs.sv
// miscellaneous and sync control register bank with serial write port
// assumes clock at 20 MHz; serial pins and sync inputs are asynchronous
`timescale 1ns/10ps
module misc_sync_control_regs
  import misc_sync_pkg::*;
#(
  parameter int TIMING_W = 8,
  parameter logic [TIMING_W-1:0] TIMING_IDLE = '0
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic serialLoad_n,
  input wire logic verticalSync,
  input wire logic horizontalSync,
  input wire logic [TIMING_W-1:0] timingIn,
  output logic [TIMING_W-1:0] timingOut,
  output logic outputsActive,
  output logic timingCoreReset_n,
  output logic clockBiasEnable,
  output logic softResetPulse,
  output logic [LINE_W-1:0] currentLine
);

  // -------------------------------------------------------------------------
  // parameter check
  // -------------------------------------------------------------------------
  if (TIMING_W < 1) begin : gBadWidth
    $error("TIMING_W must be at least 1");
  end

  localparam int SYNC_N = 5;

  logic [SYNC_N-1:0] pinRaw;
  logic [SYNC_N-1:0] stage1_reg;
  logic [SYNC_N-1:0] stage2_reg;
  logic sckSync;
  logic sdataSync;
  logic loadSync_n;
  logic vdSync;
  logic hdSync;

  logic writeStrobe;
  logic [ADDR_W-1:0] writeAddr;
  logic [DATA_W-1:0] writeData;

  logic softReset_reg;
  logic oePending_reg;
  logic oeActive_reg;
  logic coreRelease_reg;
  logic clockBias_reg;
  logic [LINE_W-1:0] loadLine_reg;
  logic loadInhibit_reg;
  logic syncPolarity_reg;

  logic vdPrev_reg;
  logic hdPrev_reg;
  logic [LINE_W-1:0] lineCount_reg;
  logic fieldLoaded_reg;
  logic outputsActive_reg;
  logic [TIMING_W-1:0] timingOut_reg;

  logic vdAsserted;
  logic hdAsserted;
  logic vdEdge;
  logic hdEdge;
  logic loadPoint;
  logic bankClear;

  // -------------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------------
  assign pinRaw = {horizontalSync, verticalSync, serialLoad_n, serialData, serialClock};

  // two flops per pin, first flop feeds only the second
  for (genvar i = 0; i < SYNC_N; i++) begin : gSync
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        stage1_reg[i] <= (i == 2);
        stage2_reg[i] <= (i == 2);
      end else begin
        stage1_reg[i] <= pinRaw[i];
        stage2_reg[i] <= stage1_reg[i];
      end
    end
  end

  assign sckSync = stage2_reg[0];
  assign sdataSync = stage2_reg[1];
  assign loadSync_n = stage2_reg[2];
  assign vdSync = stage2_reg[3];
  assign hdSync = stage2_reg[4];

  // -------------------------------------------------------------------------
  // serial write port
  // -------------------------------------------------------------------------
  serial_write_port uSerial (
    .clock(clock),
    .rst_n(rst_n),
    .sckSync(sckSync),
    .sdataSync(sdataSync),
    .loadSync_n(loadSync_n),
    .writeStrobe(writeStrobe),
    .writeAddr(writeAddr),
    .writeData(writeData)
  );

  // address match of a committed write
  function automatic logic hit(input logic [ADDR_W-1:0] ofs);
    hit = writeStrobe && (writeAddr == ofs);
  endfunction

  // -------------------------------------------------------------------------
  // soft reset
  // -------------------------------------------------------------------------
  // whole bank back to defaults
  assign bankClear = softReset_reg;

  // trigger self clears after one cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      softReset_reg <= SOFT_RESET_RST;
    end else if (softReset_reg) begin
      softReset_reg <= 1'b0;
    end else if (hit(SOFT_RESET_OFS)) begin
      softReset_reg <= writeData[SOFT_RESET_BIT];
    end
  end

  assign softResetPulse = softReset_reg;

  // -------------------------------------------------------------------------
  // immediate registers
  // -------------------------------------------------------------------------
  // immediate update at write completion
  always_ff @(posedge clock) begin
    if (!rst_n || bankClear) begin
      coreRelease_reg <= CORE_RELEASE_RST;
      clockBias_reg <= CLOCK_BIAS_RST;
      loadLine_reg <= LOAD_LINE_RST;
      loadInhibit_reg <= LOAD_INHIBIT_RST;
      syncPolarity_reg <= SYNC_POLARITY_RST;
      oePending_reg <= OUTPUT_ENABLE_RST;
    end else begin
      if (hit(TIMING_CORE_RELEASE_OFS)) begin
        coreRelease_reg <= writeData[CORE_RELEASE_BIT];
      end
      if (hit(CLOCK_INPUT_BIAS_OFS)) begin
        clockBias_reg <= writeData[CLOCK_BIAS_BIT];
      end
      if (hit(FRAME_LOAD_CONTROL_OFS)) begin
        loadLine_reg <= writeData[LOAD_LINE_LSB +: LINE_W];
        loadInhibit_reg <= writeData[LOAD_INHIBIT_BIT];
      end
      if (hit(SYNC_POLARITY_OFS)) begin
        syncPolarity_reg <= writeData[SYNC_POLARITY_BIT];
      end
      if (hit(OUTPUT_ENABLE_OFS)) begin
        oePending_reg <= writeData[OUTPUT_ENABLE_BIT];
      end
    end
  end

  assign timingCoreReset_n = coreRelease_reg;
  assign clockBiasEnable = clockBias_reg;

  // -------------------------------------------------------------------------
  // sync edges and line counter
  // -------------------------------------------------------------------------
  // polarity applied to both syncs
  assign vdAsserted = syncPolarity_reg ? vdSync : ~vdSync;
  assign hdAsserted = syncPolarity_reg ? hdSync : ~hdSync;
  assign vdEdge = vdAsserted & ~vdPrev_reg;
  assign hdEdge = hdAsserted & ~hdPrev_reg;

  // previous asserted levels
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vdPrev_reg <= 1'b1;
      hdPrev_reg <= 1'b1;
    end else begin
      vdPrev_reg <= vdAsserted;
      hdPrev_reg <= hdAsserted;
    end
  end

  // line within field, zero after vertical edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lineCount_reg <= '0;
    end else if (vdEdge) begin
      lineCount_reg <= '0;
    end else if (hdEdge) begin
      lineCount_reg <= lineCount_reg + 13'h0001;
    end
  end

  assign currentLine = lineCount_reg;

  // -------------------------------------------------------------------------
  // frame load of output enable
  // -------------------------------------------------------------------------
  // load once per field at the chosen line; inhibit blocks it
  assign loadPoint = !loadInhibit_reg && !fieldLoaded_reg && !vdEdge
                     && (lineCount_reg == loadLine_reg);

  // one load per field
  always_ff @(posedge clock) begin
    if (!rst_n || bankClear) begin
      fieldLoaded_reg <= 1'b1;
    end else if (vdEdge) begin
      fieldLoaded_reg <= 1'b0;
    end else if (loadPoint) begin
      fieldLoaded_reg <= 1'b1;
    end
  end

  // output enable waits for load point
  always_ff @(posedge clock) begin
    if (!rst_n || bankClear) begin
      oeActive_reg <= OUTPUT_ENABLE_RST;
    end else if (loadPoint) begin
      oeActive_reg <= oePending_reg;
    end
  end

  // -------------------------------------------------------------------------
  // output gating
  // -------------------------------------------------------------------------
  // start at next vertical edge; drop when disabled
  always_ff @(posedge clock) begin
    if (!rst_n || bankClear) begin
      outputsActive_reg <= 1'b0;
    end else if (!oeActive_reg) begin
      outputsActive_reg <= 1'b0;
    end else if (vdEdge) begin
      outputsActive_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timingOut_reg <= TIMING_IDLE;
    end else begin
      timingOut_reg <= outputsActive_reg ? timingIn : TIMING_IDLE;
    end
  end

  assign timingOut = timingOut_reg;
  assign outputsActive = outputsActive_reg;

endmodule

//--- tb/misc_sync_control_regs_sva.sv
// assertions on the register bank ports
// assumes binding to misc_sync_control_regs at the foot of this file
`timescale 1ns/10ps
module misc_sync_control_regs_sva
  import misc_sync_pkg::*;
#(
  parameter int TIMING_W = 8,
  parameter logic [TIMING_W-1:0] TIMING_IDLE = '0
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic serialLoad_n,
  input wire logic verticalSync,
  input wire logic horizontalSync,
  input wire logic [TIMING_W-1:0] timingIn,
  input wire logic [TIMING_W-1:0] timingOut,
  input wire logic outputsActive,
  input wire logic timingCoreReset_n,
  input wire logic clockBiasEnable,
  input wire logic softResetPulse,
  input wire logic [LINE_W-1:0] currentLine
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // soft reset: lone pulse, then empty bank
  AST_SOFT_ONE: assert property (softResetPulse |=> !softResetPulse)
    else $error("soft reset pulse too long");
  AST_SOFT_CLEAR: assert property (softResetPulse |=>
    !timingCoreReset_n && !clockBiasEnable && !outputsActive)
    else $error("bank not cleared by soft reset");
  // timing outputs follow the active flag
  AST_IDLE_OUT: assert property (!outputsActive |=> timingOut == TIMING_IDLE)
    else $error("timing output not idle");
  AST_DRIVE_OUT: assert property (outputsActive |=> timingOut == $past(timingIn))
    else $error("timing output not driven");
  AST_ACTIVE_AT_FIELD: assert property ($rose(outputsActive) |-> currentLine == 13'h0000)
    else $error("outputs started away from field start");
  AST_LINE_STEP: assert property (!$stable(currentLine) |->
    currentLine == 13'h0000 || currentLine == $past(currentLine) + 13'h0001)
    else $error("line counter jumped");
  // immediate registers move only after a closed frame
  AST_WRITE_CAUSE: assert property (
    $rose(timingCoreReset_n) || $rose(clockBiasEnable) || softResetPulse
    |-> $past(serialLoad_n, 3))
    else $error("register changed without a frame");
  AST_QUIET_STABLE: assert property (serialLoad_n [*8] |=>
    $stable(timingCoreReset_n) && $stable(clockBiasEnable))
    else $error("register changed while port quiet");
endmodule

bind misc_sync_control_regs misc_sync_control_regs_sva #(
  .TIMING_W(TIMING_W), .TIMING_IDLE(TIMING_IDLE)
) i_misc_sync_control_regs_sva (
  .clock(clock), .rst_n(rst_n), .serialClock(serialClock), .serialData(serialData),
  .serialLoad_n(serialLoad_n), .verticalSync(verticalSync), .horizontalSync(horizontalSync),
  .timingIn(timingIn), .timingOut(timingOut), .outputsActive(outputsActive),
  .timingCoreReset_n(timingCoreReset_n), .clockBiasEnable(clockBiasEnable),
  .softResetPulse(softResetPulse), .currentLine(currentLine)
);

//--- tb/host_serial_model.sv
// host model writing registers over the three-wire serial port
// assumes the 20 MHz bench clock; serial clock period 400 ns
`timescale 1ns/10ps
module host_serial_model
(
  input wire logic clock,
  output logic serialClock,
  output logic serialData,
  output logic serialLoad_n
);
  // idle: clock still, frame closed
  initial begin
    serialClock = 1'b0;
    serialData = 1'b0;
    serialLoad_n = 1'b1;
  end

  // one frame, address then data, lsb first; other than 36 bits aborts
  // callers keep test and unused fields zero
  task automatic write(input logic [7:0] addr, input logic [27:0] data, input int nbits);
    logic [35:0] frame;
    frame = {data, addr};
    @(negedge clock);
    serialLoad_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      serialData = frame[i % 36];
      repeat (4) @(negedge clock);
      serialClock = 1'b1;
      repeat (4) @(negedge clock);
      serialClock = 1'b0;
    end
    serialData = ~serialData; // inverted after the last bit, still driven
    repeat (4) @(negedge clock);
    serialLoad_n = 1'b1;
    repeat (8) @(negedge clock);
  endtask
endmodule

//--- tb/misc_sync_control_regs_tb.sv
// self-checking bench for the misc sync control register bank
// assumes host_serial_model on the serial pins and the bound checker
`timescale 1ns/10ps
module misc_sync_control_regs_tb
  import misc_sync_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic verticalSync = 1'b1;
  logic horizontalSync = 1'b1;
  logic pol = 1'b0;
  logic [7:0] timingIn = 8'h00;
  logic [7:0] timingOut, held;
  logic outputsActive, timingCoreReset_n, clockBiasEnable, softResetPulse;
  logic serialClock, serialData, serialLoad_n;
  logic [LINE_W-1:0] currentLine;
  logic [31:0] b;
  int seed = 32'h763EAAFB;
  int errors = 0;
  int total_checks = 0;
  int pulses = 0;
  int ln;

  always #25 clock = ~clock;
  // random pattern and soft reset pulse count
  always @(negedge clock) timingIn <= 8'($random(seed));
  always @(posedge clock) if (softResetPulse === 1'b1) pulses <= pulses + 1;

  misc_sync_control_regs i_misc_sync_control_regs (
    .clock(clock), .rst_n(rst_n), .serialClock(serialClock), .serialData(serialData),
    .serialLoad_n(serialLoad_n), .verticalSync(verticalSync),
    .horizontalSync(horizontalSync), .timingIn(timingIn), .timingOut(timingOut),
    .outputsActive(outputsActive), .timingCoreReset_n(timingCoreReset_n),
    .clockBiasEnable(clockBiasEnable), .softResetPulse(softResetPulse),
    .currentLine(currentLine)
  );
  host_serial_model i_host_serial_model (
    .clock(clock), .serialClock(serialClock), .serialData(serialData),
    .serialLoad_n(serialLoad_n)
  );

  // ----
  // tasks
  // ----
  task automatic check_flag(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_value(input string name, input logic [12:0] exp, input logic [12:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // expected timing output: pattern of the cycle before when active, else idle zero
  function automatic logic [7:0] exp_timing(input logic active, input logic [7:0] pattern);
    exp_timing = active ? pattern : 8'h00;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [27:0] d);
    i_host_serial_model.write(a, d, 36);
  endtask
  task automatic pulse(input logic vert);
    @(negedge clock);
    if (vert) verticalSync = pol;
    else horizontalSync = pol;
    repeat (4) @(negedge clock);
    verticalSync = ~pol;
    horizontalSync = ~pol;
    repeat (6) @(negedge clock);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #2000000;
    errors++;
    finish_test();
  end

  // ----
  // tests
  // ----
  initial begin
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    check_flag("active", 1'b0, outputsActive);
    check_flag("core", 1'b0, timingCoreReset_n);
    check_flag("bias", 1'b0, clockBiasEnable);
    $display("test reset defaults done");
    for (int k = 0; k < 4; k++) begin
      b = $random(seed);
      wr(TIMING_CORE_RELEASE_OFS, {27'h0, b[0]});
      wr(CLOCK_INPUT_BIAS_OFS, {27'h0, b[1]});
      check_flag("core", b[0], timingCoreReset_n);
      check_flag("bias", b[1], clockBiasEnable);
    end
    wr(TIMING_CORE_RELEASE_OFS, 28'h1);
    wr(CLOCK_INPUT_BIAS_OFS, 28'h1);
    i_host_serial_model.write(CLOCK_INPUT_BIAS_OFS, 28'h0, 37);
    wr(TEST_REG_A_OFS, 28'h0);
    wr(8'h1A, 28'h0);
    check_flag("bias kept", 1'b1, clockBiasEnable);
    $display("test immediate registers done");
    pulse(1'b1);
    repeat (3) pulse(1'b0);
    check_value("line", 13'h0003, currentLine);
    wr(SYNC_POLARITY_OFS, 28'h1);
    pol = 1'b1;
    verticalSync = 1'b0;
    horizontalSync = 1'b0;
    pulse(1'b1);
    repeat (2) pulse(1'b0);
    check_value("line", 13'h0002, currentLine);
    // edge must come as the pin goes high, not as it goes back low
    @(negedge clock);
    horizontalSync = pol;
    repeat (4) @(negedge clock);
    check_value("line on assert", 13'h0003, currentLine);
    horizontalSync = ~pol;
    repeat (4) @(negedge clock);
    $display("test line and polarity done");
    ln = 1 + {$random(seed)} % 3;
    wr(FRAME_LOAD_CONTROL_OFS, 28'(ln));
    pulse(1'b1);
    wr(OUTPUT_ENABLE_OFS, 28'h1);
    pulse(1'b1);
    repeat (ln) pulse(1'b0);
    check_flag("active early", 1'b0, outputsActive);
    pulse(1'b1);
    check_flag("active", 1'b1, outputsActive);
    @(posedge clock);
    held = timingIn;
    @(negedge clock);
    check_value("timing", {5'h00, exp_timing(1'b1, held)}, {5'h00, timingOut});
    $display("test output enable done");
    wr(FRAME_LOAD_CONTROL_OFS, 28'h2000 | 28'(ln));
    wr(OUTPUT_ENABLE_OFS, 28'h0);
    pulse(1'b1);
    repeat (ln) pulse(1'b0);
    pulse(1'b1);
    check_flag("active inhibited", 1'b1, outputsActive);
    wr(FRAME_LOAD_CONTROL_OFS, 28'(ln));
    pulse(1'b1);
    repeat (ln) pulse(1'b0);
    check_flag("active off", 1'b0, outputsActive);
    check_value("timing idle", {5'h00, exp_timing(1'b0, held)}, {5'h00, timingOut});
    $display("test load inhibit done");
    wr(OUTPUT_ENABLE_OFS, 28'h1);
    pulses = 0;
    wr(SOFT_RESET_OFS, 28'h1);
    check_value("soft pulses", 13'h0001, 13'(pulses));
    check_flag("core", 1'b0, timingCoreReset_n);
    check_flag("bias", 1'b0, clockBiasEnable);
    pol = 1'b0;
    verticalSync = 1'b1;
    horizontalSync = 1'b1;
    pulse(1'b1);
    repeat (ln) pulse(1'b0);
    pulse(1'b1);
    check_flag("active after soft", 1'b0, outputsActive);
    $display("test soft reset done");
    finish_test();
  end
endmodule
